// [rtl/input_cmd_decoder.sv]
// Programmable digital input command decoder with an APB register slave.
//
// Chosen here: register access over APB and the register addresses.
module input_cmd_decoder (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [cmd_decode_pkg::NUM_TERM-1:0] term_pins,
    output cmd_decode_pkg::drive_sel_t drive_sel,
    output logic run_forward,
    output logic run_backward,
    output logic drive_enable,
    output logic alarm_relay_output,
    output logic [7:0] alarm_display,
    output logic jog_ready
);

    localparam int NT = cmd_decode_pkg::NUM_TERM;
    localparam int NC = cmd_decode_pkg::NUM_CMD;
    localparam int CW = cmd_decode_pkg::CODE_W;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [CW-1:0] code_q [NT];
    logic [1:0] run_src_q;
    logic kp_press;
    logic [31:0] prdata_q;
    logic setup;
    logic access;
    logic mapped;
    logic [31:0] rd_d;

    // ------------------------------------------------------------
    // Decoder state
    // ------------------------------------------------------------
    logic [NT-1:0] pins_s;
    logic [NT-1:0] hit;
    logic [cmd_decode_pkg::IDX_W-1:0] idx [NT];
    logic [NC-1:0] cmd;
    logic [NC-1:0] cmd_prev_q;
    logic hold_assigned;
    logic [3:0] sel_idx;
    cmd_decode_pkg::drive_sel_t drive_sel_q;
    logic fwd_latch_q;
    logic bwd_latch_q;
    logic run_fwd_q;
    logic run_bwd_q;
    logic drive_en_q;
    logic trip_q;
    logic alarm_relay_q;
    logic [7:0] alarm_disp_q;
    logic jog_toggle_q;
    logic jog_ready_q;
    logic keypad_src;
    logic rst_rise;
    logic rst_fall;

    // ------------------------------------------------------------
    // Terminal input path
    // ------------------------------------------------------------

    // Pins arrive from contacts outside the clock domain.
    bit_sync #(.W(NT)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d(term_pins),
        .q(pins_s)
    );

    // One decoder per terminal; the two last ones are the run terminals.
    for (genvar t = 0; t < NT; t++) begin : g_term
        term_decode #(.RUN_TERM(t >= NT - 2)) u_dec (
            .code(code_q[t]),
            .level(pins_s[t]),
            .hit(hit[t]),
            .idx(idx[t])
        );
    end

    // Merge every terminal into one command vector; absent commands stay 0.
    always_comb begin
        cmd = '0;
        hold_assigned = 1'b0;
        for (int t = 0; t < NT; t++) begin
            if (hit[t])
                cmd[idx[t]] = 1'b1;
            if (code_q[t] == CW'(cmd_decode_pkg::CODE_HOLD) ||
                code_q[t] == CW'(cmd_decode_pkg::CODE_HOLD) +
                             cmd_decode_pkg::NEG_OFFSET)
                hold_assigned = 1'b1;
        end
    end

    assign sel_idx = {cmd[cmd_decode_pkg::CMD_SEL3],
                      cmd[cmd_decode_pkg::CMD_SEL2],
                      cmd[cmd_decode_pkg::CMD_SEL1],
                      cmd[cmd_decode_pkg::CMD_SEL0]};
    assign rst_rise = cmd[cmd_decode_pkg::CMD_ALM_RST] &&
                      !cmd_prev_q[cmd_decode_pkg::CMD_ALM_RST];
    assign rst_fall = !cmd[cmd_decode_pkg::CMD_ALM_RST] &&
                      cmd_prev_q[cmd_decode_pkg::CMD_ALM_RST];
    assign keypad_src = run_src_q != cmd_decode_pkg::RUN_SRC_INPUT;

    // Previous command levels, used for edge detection.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cmd_prev_q <= '0;
        else if (ce)
            cmd_prev_q <= cmd;
    end

    // ------------------------------------------------------------
    // Selection outputs
    // ------------------------------------------------------------

    // Selections are plain levels registered once for a clean output.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_sel_q <= '0;
        end else if (ce) begin
            drive_sel_q.preset_index <= sel_idx;
            drive_sel_q.use_preset <= sel_idx != 4'h0;
            drive_sel_q.ramp_set2 <= cmd[cmd_decode_pkg::CMD_RAMP];
            drive_sel_q.speed_source2 <=
                cmd[cmd_decode_pkg::CMD_SPEED_SRC];
            drive_sel_q.motor2 <= cmd[cmd_decode_pkg::CMD_MOTOR];
            drive_sel_q.dc_brake <= cmd[cmd_decode_pkg::CMD_DC_BRAKE];
            drive_sel_q.torque_limit2 <= cmd[cmd_decode_pkg::CMD_TORQUE];
            drive_sel_q.force_stop <=
                cmd[cmd_decode_pkg::CMD_FORCE_STOP];
        end
    end

    // ------------------------------------------------------------
    // Run control, 2-wire and 3-wire
    // ------------------------------------------------------------

    // The self-hold latch takes only the first run edge while hold is ON.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_latch_q <= 1'b0;
            bwd_latch_q <= 1'b0;
        end else if (ce) begin
            if (!cmd[cmd_decode_pkg::CMD_HOLD]) begin
                fwd_latch_q <= 1'b0;
                bwd_latch_q <= 1'b0;
            end else if (!fwd_latch_q && !bwd_latch_q) begin
                if (cmd[cmd_decode_pkg::CMD_RUN_FWD] &&
                    !cmd_prev_q[cmd_decode_pkg::CMD_RUN_FWD])
                    fwd_latch_q <= 1'b1;
                else if (cmd[cmd_decode_pkg::CMD_RUN_BWD] &&
                         !cmd_prev_q[cmd_decode_pkg::CMD_RUN_BWD])
                    bwd_latch_q <= 1'b1;
            end
        end
    end

    // Both run inputs at once in 2-wire mode means stop, never a guess.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_fwd_q <= 1'b0;
            run_bwd_q <= 1'b0;
        end else if (ce) begin
            if (hold_assigned) begin
                run_fwd_q <= fwd_latch_q;
                run_bwd_q <= bwd_latch_q;
            end else begin
                run_fwd_q <= cmd[cmd_decode_pkg::CMD_RUN_FWD] &&
                             !cmd[cmd_decode_pkg::CMD_RUN_BWD];
                run_bwd_q <= cmd[cmd_decode_pkg::CMD_RUN_BWD] &&
                             !cmd[cmd_decode_pkg::CMD_RUN_FWD];
            end
        end
    end

    // ------------------------------------------------------------
    // Output enable, external trip and alarm
    // ------------------------------------------------------------

    // Coast and trip both cut the output on the next edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            drive_en_q <= 1'b0;
        else if (ce)
            drive_en_q <= !(cmd[cmd_decode_pkg::CMD_COAST] ||
                            cmd[cmd_decode_pkg::CMD_EXT_TRIP] || trip_q);
    end

    // A live trip wins over a reset so no trip event is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_q <= 1'b0;
            alarm_relay_q <= 1'b0;
            alarm_disp_q <= cmd_decode_pkg::ALARM_CODE_NONE;
        end else if (ce) begin
            if (cmd[cmd_decode_pkg::CMD_EXT_TRIP]) begin
                trip_q <= 1'b1;
                alarm_relay_q <= 1'b1;
                alarm_disp_q <= cmd_decode_pkg::ALARM_CODE_EXT;
            end else begin
                if (rst_rise)
                    alarm_relay_q <= 1'b0;
                if (rst_fall) begin
                    trip_q <= 1'b0;
                    alarm_disp_q <= cmd_decode_pkg::ALARM_CODE_NONE;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Jog-ready state
    // ------------------------------------------------------------

    // The key toggle only counts with keypad source and jog input OFF.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            jog_toggle_q <= 1'b0;
        else if (ce && keypad_src && kp_press &&
                 !cmd[cmd_decode_pkg::CMD_JOG])
            jog_toggle_q <= !jog_toggle_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            jog_ready_q <= 1'b0;
        else if (ce)
            jog_ready_q <= cmd[cmd_decode_pkg::CMD_JOG] ||
                           (keypad_src && jog_toggle_q);
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign setup = psel && !penable;
    assign access = psel && penable && ce;
    assign mapped = paddr[1:0] == 2'h0 && paddr <= cmd_decode_pkg::OFF_CMDS;
    assign kp_press = access && pwrite &&
                      paddr == cmd_decode_pkg::OFF_KEYPAD && pwdata[0];
    assign pready = ce;
    assign pslverr = access && !mapped;
    assign prdata = prdata_q;

    // Read data is captured in the setup cycle so it leaves a flop.
    always_comb begin
        rd_d = '0;
        if (paddr < cmd_decode_pkg::OFF_RUN_SRC)
            rd_d = 32'(code_q[paddr[4:2]]);
        else if (paddr == cmd_decode_pkg::OFF_RUN_SRC)
            rd_d = {30'h0000_0000, run_src_q};
        else if (paddr == cmd_decode_pkg::OFF_KEYPAD)
            rd_d = {31'h0000_0000, jog_toggle_q};
        else if (paddr == cmd_decode_pkg::OFF_STATUS)
            rd_d = {16'h0000, cmd[cmd_decode_pkg::CMD_RUN_BWD],
                    hold_assigned, alarm_disp_q, jog_ready_q,
                    alarm_relay_q, trip_q, drive_en_q, run_bwd_q, run_fwd_q};
        else if (paddr == cmd_decode_pkg::OFF_CMDS)
            rd_d = cmd[31:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata_q <= '0;
        else if (ce && setup)
            prdata_q <= mapped ? rd_d : 32'h0000_0000;
    end

    // Writes take effect at the access edge; the keypad word is a pulse.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int t = 0; t < NT; t++)
                code_q[t] <= cmd_decode_pkg::CODE_RESET[t];
            run_src_q <= cmd_decode_pkg::RUN_SRC_RESET;
        end else if (access && pwrite) begin
            if (paddr < cmd_decode_pkg::OFF_RUN_SRC && paddr[1:0] == 2'h0)
                code_q[paddr[4:2]] <= pwdata[CW-1:0];
            if (paddr == cmd_decode_pkg::OFF_RUN_SRC)
                run_src_q <= pwdata[1:0];
        end
    end

    assign drive_sel = drive_sel_q;
    assign run_forward = run_fwd_q;
    assign run_backward = run_bwd_q;
    assign drive_enable = drive_en_q;
    assign alarm_relay_output = alarm_relay_q;
    assign alarm_display = alarm_disp_q;
    assign jog_ready = jog_ready_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_trip_cuts_out: assert property (
        ce && cmd[cmd_decode_pkg::CMD_EXT_TRIP] |=>
            !drive_enable && alarm_relay_output && trip_q &&
            alarm_display == cmd_decode_pkg::ALARM_CODE_EXT)
        else $error("external trip did not cut output and raise alarm");
    a_coast_no_alarm: assert property (
        ce && cmd[cmd_decode_pkg::CMD_COAST] && !trip_q &&
        !cmd[cmd_decode_pkg::CMD_EXT_TRIP] |=>
            !drive_enable && !alarm_relay_output)
        else $error("coast stop wrong");
    a_trip_stays: assert property (
        ce && trip_q && !rst_fall |=> trip_q)
        else $error("trip released without alarm reset");
    a_reset_relay: assert property (
        ce && rst_rise && !cmd[cmd_decode_pkg::CMD_EXT_TRIP] |=>
            !alarm_relay_output)
        else $error("alarm reset did not clear relay");
    a_two_wire_run: assert property (
        ce && !hold_assigned |=> run_forward ==
            ($past(cmd[cmd_decode_pkg::CMD_RUN_FWD]) &&
             !$past(cmd[cmd_decode_pkg::CMD_RUN_BWD])))
        else $error("2-wire run did not follow input");
    a_hold_release: assert property (
        ce && hold_assigned && !cmd[cmd_decode_pkg::CMD_HOLD] ##1 ce |=>
            !run_forward && !run_backward)
        else $error("self-hold not released");
    a_preset_index: assert property (
        ce |=> drive_sel.preset_index == $past(sel_idx) &&
            drive_sel.use_preset == ($past(sel_idx) != 4'h0))
        else $error("preset index wrong");
    a_jog_forced: assert property (
        ce && cmd[cmd_decode_pkg::CMD_JOG] |=> jog_ready)
        else $error("jog command did not force jog-ready");
    a_jog_input_src: assert property (
        ce && !keypad_src |=> jog_ready == $past(cmd[cmd_decode_pkg::CMD_JOG]))
        else $error("jog-ready ignored input source");
    a_key_toggle: assert property (
        ce && keypad_src && kp_press && !cmd[cmd_decode_pkg::CMD_JOG] |=>
            jog_toggle_q != $past(jog_toggle_q))
        else $error("keypad jog press did not toggle");

    c_trip_reset: cover property (trip_q ##[1:50] !trip_q);
    c_hold_latch: cover property (hold_assigned && fwd_latch_q);
    c_key_jog: cover property (keypad_src && kp_press ##1 jog_ready);

endmodule : input_cmd_decoder

// [rtl/cmd_decode_pkg.sv]
// Behaviour
// - Each of seven terminals takes programmable function code.
// - Code plus 1000 asserts command when terminal OFF.
// - Codes 0-3 speed bits, 4,6,7,8,10 basic commands.
// - Codes 11 through 46 decode per assignment table.
// - No negative form for 13, 98, 99; runs restricted.
// - Alarm trip and forced stop use inverted polarity.
// - Four select bits form preset index; zero ordinary.
// - Ramp set 2 only while ramp select is ON.
// - Self-hold latches first run edge; released when OFF.
// - Without self-hold, run follows run inputs directly.
// - Coast stop disables output at once, no alarm.
// - Reset assert clears relay; release clears display, hold.
// - External trip disables output, shows code, latches.
// - Jog command always forces jog-ready state.
// - Keypad source: key press toggles jog-ready state.
// - Input source: keys ignored, jog follows command.
// - Speed source 2 only while source select ON.
package cmd_decode_pkg;

    // ------------------------------------------------------------
    // Sizes and function code encoding
    // ------------------------------------------------------------
    localparam int NUM_TERM = 7;
    localparam int CODE_W = 11;
    localparam int NUM_CMD = 33;
    localparam int IDX_W = 6;
    localparam logic [CODE_W-1:0] NEG_OFFSET = 11'h3e8;
    localparam logic [CODE_W-1:0] CODE_LIMIT = 11'h064;
    localparam logic [6:0] CODE_DC_BRAKE = 7'h0d;
    localparam logic [6:0] CODE_EXT_TRIP = 7'h09;
    localparam logic [6:0] CODE_FORCE_STOP = 7'h1e;
    localparam logic [6:0] CODE_RUN_FWD = 7'h62;
    localparam logic [6:0] CODE_RUN_BWD = 7'h63;
    localparam logic [6:0] CODE_HOLD = 7'h06;

    // ------------------------------------------------------------
    // Command bit positions in the decoded command vector
    // ------------------------------------------------------------
    localparam int CMD_SEL0 = 0;
    localparam int CMD_SEL1 = 1;
    localparam int CMD_SEL2 = 2;
    localparam int CMD_SEL3 = 3;
    localparam int CMD_RAMP = 4;
    localparam int CMD_HOLD = 5;
    localparam int CMD_COAST = 6;
    localparam int CMD_ALM_RST = 7;
    localparam int CMD_EXT_TRIP = 8;
    localparam int CMD_JOG = 9;
    localparam int CMD_SPEED_SRC = 10;
    localparam int CMD_MOTOR = 11;
    localparam int CMD_DC_BRAKE = 12;
    localparam int CMD_TORQUE = 13;
    localparam int CMD_FORCE_STOP = 23;
    localparam int CMD_RUN_FWD = 31;
    localparam int CMD_RUN_BWD = 32;

    // ------------------------------------------------------------
    // Register map, reset values and run source encoding
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CODE0 = 8'h00;
    localparam logic [7:0] OFF_RUN_SRC = 8'h1c;
    localparam logic [7:0] OFF_KEYPAD = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_CMDS = 8'h28;
    localparam logic [1:0] RUN_SRC_INPUT = 2'h1;
    localparam logic [1:0] RUN_SRC_RESET = 2'h0;
    localparam logic [CODE_W-1:0] CODE_RESET [NUM_TERM] = '{
        11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h062, 11'h063};
    // Display code for an external trip; the value is arbitrary.
    localparam logic [7:0] ALARM_CODE_EXT = 8'h0a;
    localparam logic [7:0] ALARM_CODE_NONE = 8'h00;

    // Drive-facing outputs that travel together.
    typedef struct packed {
        logic [3:0] preset_index;
        logic use_preset;
        logic ramp_set2;
        logic speed_source2;
        logic motor2;
        logic dc_brake;
        logic torque_limit2;
        logic force_stop;
    } drive_sel_t;

endpackage : cmd_decode_pkg

// [rtl/bit_sync.sv]
// Two-stage synchroniser for asynchronous input pins.
module bit_sync #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            q <= '0;
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule : bit_sync

// [rtl/term_decode.sv]
// Maps one synchronised terminal level and its function code to a command.
module term_decode #(
    parameter bit RUN_TERM = 1'b0
) (
    input wire logic [cmd_decode_pkg::CODE_W-1:0] code,
    input wire logic level,
    output logic hit,
    output logic [cmd_decode_pkg::IDX_W-1:0] idx
);

    localparam int IDX_W = cmd_decode_pkg::IDX_W;

    logic negated;
    logic [cmd_decode_pkg::CODE_W-1:0] base;
    logic known;
    logic [6:0] b7;

    // Strip the negative-logic offset, then look up the command index.
    always_comb begin
        negated = code >= cmd_decode_pkg::NEG_OFFSET;
        base = negated ? code - cmd_decode_pkg::NEG_OFFSET : code;
        b7 = base[6:0];
        known = base < cmd_decode_pkg::CODE_LIMIT;
        idx = '0;
        case (b7)
            7'h00, 7'h01, 7'h02, 7'h03, 7'h04: idx = IDX_W'(b7);
            7'h06, 7'h07, 7'h08, 7'h09, 7'h0a: idx = IDX_W'(b7 - 7'h01);
            7'h0b, 7'h0c, 7'h0d, 7'h0e: idx = IDX_W'(b7 - 7'h01);
            7'h11, 7'h12, 7'h13, 7'h14, 7'h15: idx = IDX_W'(b7 - 7'h03);
            7'h18, 7'h19, 7'h1a, 7'h1b: idx = IDX_W'(b7 - 7'h05);
            7'h1e: idx = IDX_W'(cmd_decode_pkg::CMD_FORCE_STOP);
            7'h21, 7'h22: idx = IDX_W'(b7 - 7'h09);
            7'h2a, 7'h2b, 7'h2c, 7'h2d, 7'h2e: idx = IDX_W'(b7 - 7'h10);
            7'h62: idx = IDX_W'(cmd_decode_pkg::CMD_RUN_FWD);
            7'h63: idx = IDX_W'(cmd_decode_pkg::CMD_RUN_BWD);
            default: known = 1'b0;
        endcase
        // Run codes belong to the run terminals only, and have no OFF form.
        if ((b7 == cmd_decode_pkg::CODE_RUN_FWD ||
             b7 == cmd_decode_pkg::CODE_RUN_BWD) && (negated || !RUN_TERM))
            known = 1'b0;
        if (b7 == cmd_decode_pkg::CODE_DC_BRAKE && negated)
            known = 1'b0;
        // Fail-safe commands trip on an open contact with the plain code.
        if (b7 == cmd_decode_pkg::CODE_EXT_TRIP ||
            b7 == cmd_decode_pkg::CODE_FORCE_STOP)
            negated = !negated;
        hit = known && (level ^ negated);
    end

endmodule : term_decode

// [test/contact_bank.sv]
// ------------------------------------------------------------
// Contact bank at the far side of the terminals
// ------------------------------------------------------------
module contact_bank #(
    parameter int HOLD_CYC = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [6:0] want,
    output logic [6:0] term_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_q [7];
    // A closed contact stays closed for a minimum time once made.
    // The time is scaled down, since the decoder itself keeps no timer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            term_pins <= '0;
            for (int i = 0; i < 7; i++) left_q[i] <= 8'h00;
        end else begin
            for (int i = 0; i < 7; i++) begin
                if (want[i] && !term_pins[i]) left_q[i] <= 8'(HOLD_CYC);
                else if (left_q[i] != 8'h00) left_q[i] <= left_q[i] - 8'h01;
                term_pins[i] <= want[i] | (left_q[i] != 8'h00);
            end
        end
    end
endmodule : contact_bank

// [test/programmable_input_command_decoder_bench.sv]
module programmable_input_command_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [6:0] want, term_pins;
    cmd_decode_pkg::drive_sel_t drive_sel;
    logic run_forward, run_backward, drive_enable, alarm_relay_output;
    logic [7:0] alarm_display;
    logic jog_ready;
    int n_fail = 0, samples_checked = 0, cyc = 0;
    // Rows: terminal levels and the expected {index, use_preset, ramp}.
    logic [6:0] row_pin [6] = '{7'h00, 7'h01, 7'h0f, 7'h08, 7'h10, 7'h1a};
    logic [5:0] row_exp [6] = '{6'h00, 6'h06, 6'h3e, 6'h22, 6'h01, 6'h2b};
    input_cmd_decoder u_dut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .term_pins(term_pins), .drive_sel(drive_sel),
        .run_forward(run_forward), .run_backward(run_backward),
        .drive_enable(drive_enable), .alarm_relay_output(alarm_relay_output),
        .alarm_display(alarm_display), .jog_ready(jog_ready));
    contact_bank u_bank (.pclk(pclk), .presetn(presetn), .want(want),
        .term_pins(term_pins));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic chk(input string nm, input logic [31:0] s, x);
        samples_checked++;
        if (s !== x) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    // One APB transfer; the request holds until pready is seen high.
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Register write by word index, then time for the outputs to follow.
    task automatic wc(input int t, input logic [31:0] d);
        apb(1'b1, 8'(t * 4), d);
        repeat (5) @(posedge pclk);
    endtask : wc
    // Long enough for the contact hold and the three-edge decode path.
    task automatic pins(input logic [6:0] v);
        @(posedge pclk);
        want <= v;
        repeat (16) @(posedge pclk);
    endtask : pins
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // A hang counts as a mismatch and closes the run.
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            wrap_up();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, want} = '0;
        ce = 1'b1;
        repeat (19) @(posedge pclk);
        chk("enable in reset", drive_enable, 0);
        @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        chk("enable after reset", drive_enable, 1);
        apb(1'b0, 8'h14, 0);
        chk("fwd code reset", r, 32'h62);
        foreach (row_pin[i]) begin
            pins(row_pin[i]);
            chk("preset and ramp", drive_sel[10:5], row_exp[i]);
        end
        wc(0, 32'h03e8);
        pins(7'h00);
        chk("negative select", drive_sel[10:6], 5'h03);
        wc(0, 32'h0062);
        pins(7'h01);
        chk("run code refused", run_forward, 0);
        wc(0, 0);
        pins(7'h20);
        chk("two wire on", run_forward, 1);
        pins(7'h40);
        chk("two wire reverse", run_backward, 1);
        pins(7'h00);
        chk("two wire off", run_forward, 0);
        wc(4, 6);
        pins(7'h10);
        pins(7'h30);
        pins(7'h10);
        chk("hold latched", run_forward, 1);
        pins(7'h50);
        chk("second run ignored", run_backward, 0);
        pins(7'h00);
        chk("hold released", run_forward, 0);
        wc(4, 7);
        pins(7'h10);
        chk("coast", drive_enable, 0);
        chk("coast no alarm", alarm_relay_output, 0);
        pins(7'h08);
        wc(3, 9);
        wc(2, 8);
        chk("no trip while on", drive_enable, 1);
        pins(7'h00);
        chk("trip output", drive_enable, 0);
        chk("trip relay", alarm_relay_output, 1);
        chk("trip display", alarm_display, 8'h0a);
        pins(7'h08);
        chk("trip latched", alarm_relay_output, 1);
        pins(7'h0c);
        chk("reset clears relay", alarm_relay_output, 0);
        chk("display kept", alarm_display, 8'h0a);
        pins(7'h08);
        chk("display cleared", alarm_display, 8'h00);
        chk("output back", drive_enable, 1);
        wc(3, 3);
        pins(7'h00);
        wc(3, 32'h03f1);
        chk("trip on ON only", drive_enable, 1);
        pins(7'h08);
        chk("trip when ON", drive_enable, 0);
        wc(1, 30);
        chk("stop when off", drive_sel[0], 1);
        wc(1, 32'h0406);
        chk("stop on ON only", drive_sel[0], 0);
        wc(8, 1);
        chk("key toggles on", jog_ready, 1);
        wc(8, 1);
        chk("key toggles off", jog_ready, 0);
        wc(7, 1);
        wc(8, 1);
        chk("key ignored", jog_ready, 0);
        wc(4, 10);
        pins(7'h10);
        chk("jog command", jog_ready, 1);
        pins(7'h00);
        chk("jog released", jog_ready, 0);
        wc(4, 11);
        pins(7'h10);
        chk("speed source", drive_sel[4], 1);
        wc(0, 32'h03f5);
        chk("brake has no off form", drive_sel[2], 0);
        wc(4, 12);
        chk("motor select", drive_sel[3], 1);
        wc(4, 13);
        chk("dc brake", drive_sel[2], 1);
        wc(4, 14);
        chk("torque select", drive_sel[1], 1);
        apb(1'b0, 8'h2c, 0);
        chk("unmapped error", e, 1);
        chk("unmapped data", r, 0);
        // A second reset in mid-run must drop the latched trip and codes.
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("enable held in reset", drive_enable, 0);
        presetn <= 1'b1;
        apb(1'b0, 8'h10, 0);
        chk("code after reset", r, 32'h4);
        chk("relay after reset", alarm_relay_output, 0);
        chk("enable after second reset", drive_enable, 1);
        wrap_up();
    end
endmodule : programmable_input_command_decoder_bench
